// *** rtl/dsd_pkg.sv ***
/*
  Shared constants and types for the data space address decoder:
  region bounds, variant limits, pointer register indices, access
  timing and the request encodings.
  Assumes a single CPU clock and a core that forms the requests.
*/
package dsd_pkg;

  // Data space region bounds
  localparam logic [15:0] REG_FIRST  = 16'h0000;
  localparam logic [15:0] REG_LAST   = 16'h001F;
  localparam logic [15:0] IO_FIRST   = 16'h0020;
  localparam logic [15:0] IO_LAST    = 16'h005F;
  localparam logic [15:0] EXT_FIRST  = 16'h0060;
  localparam logic [15:0] EXT_LAST   = 16'h00FF;
  localparam logic [15:0] SRAM_FIRST = 16'h0100;
  localparam logic [15:0] SRAM_LAST_LARGE = 16'h0AFF;
  localparam logic [15:0] SRAM_LAST_SMALL = 16'h05FF;

  // Program memory, word addressed, and nonvolatile store limits
  localparam logic [15:0] FLASH_LAST_LARGE = 16'h3FFF;
  localparam logic [15:0] FLASH_LAST_SMALL = 16'h1FFF;
  localparam logic [11:0] NV_LAST_LARGE    = 12'h03FF;
  localparam logic [11:0] NV_LAST_SMALL    = 12'h01FF;

  // Low register index of each pointer pair
  localparam logic [4:0] PTR_X_LO_IDX = 5'h1A;
  localparam logic [4:0] PTR_Y_LO_IDX = 5'h1C;
  localparam logic [4:0] PTR_Z_LO_IDX = 5'h1E;

  // Cycle counts per access; SRAM needs two, the rest one
  localparam logic [1:0] SRAM_CYCLES  = 2'h2;
  localparam logic [1:0] OTHER_CYCLES = 2'h1;
  localparam logic [15:0] PTR_STEP    = 16'h0001;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  // Decoded region of one data address
  typedef enum logic [2:0] {
    RGN_NONE, RGN_REG, RGN_IO, RGN_EXT, RGN_SRAM
  } dsd_region_type;

  // Five data addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT, MODE_DISP, MODE_INDIRECT, MODE_PREDEC, MODE_POSTINC
  } dsd_mode_type;

  // Pointer selection
  typedef enum logic [1:0] {
    PTR_X, PTR_Y, PTR_Z
  } dsd_ptr_type;

endpackage : dsd_pkg

// *** rtl/dsd_region_decode.sv ***
/*
  Combinational sorter of one 16-bit data address into its region.
  Assumes the caller registers the result; the SRAM end is a build
  parameter chosen by the variant.
*/
module dsd_region_decode #(
  parameter logic [15:0] SRAM_LAST = dsd_pkg::SRAM_LAST_LARGE
) (
  // Address in, region out
  input  wire logic [15:0]             addr_i,
  output dsd_pkg::dsd_region_type      region_o
);

  // Ranges are contiguous, so only upper bounds need checking
  always_comb begin
    if (addr_i <= dsd_pkg::REG_LAST) begin
      region_o = dsd_pkg::RGN_REG;
    end else if (addr_i <= dsd_pkg::IO_LAST) begin
      region_o = dsd_pkg::RGN_IO;
    end else if (addr_i <= dsd_pkg::EXT_LAST) begin
      region_o = dsd_pkg::RGN_EXT;
    end else if (addr_i <= SRAM_LAST) begin
      region_o = dsd_pkg::RGN_SRAM;
    end else begin
      region_o = dsd_pkg::RGN_NONE;
    end
  end

endmodule // dsd_region_decode

// *** rtl/dsd_top.sv ***
/*
  Data space address decoder: effective address generation for the
  five data addressing modes, region selection, access timing,
  pointer write-back and program / nonvolatile address checks.
  Assumes the core holds each request stable while it waits for
  READY_O, and that region targets answer reads within the access.
*/
module dsd_top #(
  parameter bit          LARGE_VARIANT   = 1'b1,
  parameter logic [15:0] BOOT_FIRST_WORD = 16'h3000
) (
  // Clock and reset
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RST_B_I,
  // Access request from the core
  input  wire logic                 REQ_VALID_I,
  input  wire dsd_pkg::dsd_mode_type REQ_MODE_I,
  input  wire dsd_pkg::dsd_ptr_type  REQ_PTR_SEL_I,
  input  wire logic                 REQ_IO_SHORT_I,
  input  wire logic [5:0]           REQ_IO_INDEX_I,
  input  wire logic [15:0]          REQ_DIRECT_ADDR_I,
  input  wire logic [5:0]           REQ_DISP_I,
  input  wire logic                 REQ_WRITE_I,
  input  wire logic [7:0]           REQ_WDATA_I,
  input  wire logic [47:0]          PTR_REGS_I,
  output logic                      READY_O,
  output logic                      DONE_O,
  output logic [7:0]                RDATA_O,
  // Region side
  output logic [15:0]               ADDR_O,
  output logic                      SEL_REG_O,
  output logic                      SEL_IO_O,
  output logic                      SEL_EXT_O,
  output logic                      SEL_SRAM_O,
  output logic                      WR_EN_O,
  output logic [7:0]                WDATA_O,
  input  wire logic [7:0]           RD_REG_I,
  input  wire logic [7:0]           RD_IO_I,
  input  wire logic [7:0]           RD_EXT_I,
  input  wire logic [7:0]           RD_SRAM_I,
  // Pointer write-back
  output logic                      PTR_WB_VALID_O,
  output logic [4:0]                PTR_WB_IDX_O,
  output logic [15:0]               PTR_WB_VAL_O,
  // Program counter and nonvolatile address checks
  input  wire logic [15:0]          PROGRAM_COUNTER_I,
  input  wire logic [11:0]          NV_ADDR_I,
  output logic                      PC_IN_RANGE_O,
  output logic                      PC_IN_BOOT_O,
  output logic                      NV_ADDR_OK_O
);

  // Variant limits
  localparam logic [15:0] INTERNAL_SRAM_LAST_ADDRESS = LARGE_VARIANT ?
    dsd_pkg::SRAM_LAST_LARGE : dsd_pkg::SRAM_LAST_SMALL;
  localparam logic [15:0] FLASH_LAST = LARGE_VARIANT ?
    dsd_pkg::FLASH_LAST_LARGE : dsd_pkg::FLASH_LAST_SMALL;
  localparam logic [11:0] NONVOLATILE_LAST_ADDRESS = LARGE_VARIANT ?
    dsd_pkg::NV_LAST_LARGE : dsd_pkg::NV_LAST_SMALL;

  // Access state
  typedef enum logic [0:0] {ST_IDLE, ST_HOLD} dsd_state_type;

  dsd_state_type           state_q;     // Idle or holding an access
  logic [1:0]              cnt_q;       // Cycles the address has stood
  dsd_pkg::dsd_region_type region_q;    // Region of the held access
  dsd_pkg::dsd_region_type region_w;    // Region of the new address
  logic [15:0]             ptr_w;       // Selected pointer value
  logic [15:0]             ea_w;        // Effective address
  logic                    wb_w;        // Mode updates the pointer
  logic [15:0]             wb_val_w;    // Updated pointer value
  logic                    accept_w;    // Request taken this edge
  logic                    wb_pend_q;   // Write-back due at finish
  logic                    finish_w;    // Access completes this edge

  // Pick a pointer pair out of R26..R31, low byte first
  function automatic logic [15:0] ptr_of(input dsd_pkg::dsd_ptr_type s,
                                         input logic [47:0] r);
    case (s)
      dsd_pkg::PTR_X: ptr_of = r[15:0];
      dsd_pkg::PTR_Y: ptr_of = r[31:16];
      default:        ptr_of = r[47:32];
    endcase
  endfunction

  // Register index of the low half of a pointer pair
  function automatic logic [4:0] ptr_idx(input dsd_pkg::dsd_ptr_type s);
    case (s)
      dsd_pkg::PTR_X: ptr_idx = dsd_pkg::PTR_X_LO_IDX;
      dsd_pkg::PTR_Y: ptr_idx = dsd_pkg::PTR_Y_LO_IDX;
      default:        ptr_idx = dsd_pkg::PTR_Z_LO_IDX;
    endcase
  endfunction

  // Displacement has no X form, so an X select falls back to Y
  always_comb begin
    if (REQ_MODE_I == dsd_pkg::MODE_DISP &&
        REQ_PTR_SEL_I == dsd_pkg::PTR_X) begin
      ptr_w = ptr_of(dsd_pkg::PTR_Y, PTR_REGS_I);
    end else begin
      ptr_w = ptr_of(REQ_PTR_SEL_I, PTR_REGS_I);
    end
  end

  // Effective address and pointer update for each mode
  always_comb begin
    wb_w     = 1'b0;
    wb_val_w = ptr_w;
    if (REQ_IO_SHORT_I) begin
      // Six-bit index cannot leave the standard block
      ea_w = dsd_pkg::IO_FIRST + {10'h000, REQ_IO_INDEX_I};
    end else begin
      case (REQ_MODE_I)
        dsd_pkg::MODE_DIRECT:   ea_w = REQ_DIRECT_ADDR_I;
        dsd_pkg::MODE_DISP: begin
          ea_w = ptr_w + {10'h000, REQ_DISP_I};
        end
        dsd_pkg::MODE_INDIRECT: ea_w = ptr_w;
        dsd_pkg::MODE_PREDEC: begin
          ea_w     = ptr_w - dsd_pkg::PTR_STEP;
          wb_w     = 1'b1;
          wb_val_w = ptr_w - dsd_pkg::PTR_STEP;
        end
        dsd_pkg::MODE_POSTINC: begin
          ea_w     = ptr_w;
          wb_w     = 1'b1;
          wb_val_w = ptr_w + dsd_pkg::PTR_STEP;
        end
        default:                ea_w = REQ_DIRECT_ADDR_I;
      endcase
    end
  end

  // Region sort; the same decoder serves every mode
  dsd_region_decode #(
    .SRAM_LAST (INTERNAL_SRAM_LAST_ADDRESS)
  ) u_decode (
    .addr_i   (ea_w),
    .region_o (region_w)
  );

  assign accept_w = REQ_VALID_I && READY_O;
  assign finish_w = (state_q == ST_HOLD) &&
                    (cnt_q == ((region_q == dsd_pkg::RGN_SRAM) ?
                     dsd_pkg::SRAM_CYCLES : dsd_pkg::OTHER_CYCLES));

  // Access sequencing; SRAM holds its address one cycle longer
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 2'h0;
      region_q <= dsd_pkg::RGN_NONE;
      READY_O  <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept_w) begin
            state_q  <= ST_HOLD;
            cnt_q    <= dsd_pkg::OTHER_CYCLES;
            region_q <= region_w;
            READY_O  <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (finish_w) begin
            state_q <= ST_IDLE;
            READY_O <= 1'b1;
          end else begin
            cnt_q <= cnt_q + dsd_pkg::OTHER_CYCLES;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          READY_O <= 1'b1;
        end
      endcase
    end
  end

  // Address, selects and write enable stand for the whole access
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ADDR_O     <= dsd_pkg::REG_FIRST;
      SEL_REG_O  <= 1'b0;
      SEL_IO_O   <= 1'b0;
      SEL_EXT_O  <= 1'b0;
      SEL_SRAM_O <= 1'b0;
      WR_EN_O    <= 1'b0;
      WDATA_O    <= dsd_pkg::ZERO_BYTE;
    end else if (accept_w) begin
      ADDR_O     <= ea_w;
      SEL_REG_O  <= (region_w == dsd_pkg::RGN_REG);
      SEL_IO_O   <= (region_w == dsd_pkg::RGN_IO);
      SEL_EXT_O  <= (region_w == dsd_pkg::RGN_EXT);
      SEL_SRAM_O <= (region_w == dsd_pkg::RGN_SRAM);
      // Unmapped writes are dropped here
      WR_EN_O    <= REQ_WRITE_I &&
                    (region_w != dsd_pkg::RGN_NONE);
      WDATA_O    <= REQ_WDATA_I;
    end else if (finish_w) begin
      SEL_REG_O  <= 1'b0;
      SEL_IO_O   <= 1'b0;
      SEL_EXT_O  <= 1'b0;
      SEL_SRAM_O <= 1'b0;
      WR_EN_O    <= 1'b0;
    end
  end

  // Completion strobe and read data capture
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DONE_O  <= 1'b0;
      RDATA_O <= dsd_pkg::ZERO_BYTE;
    end else begin
      DONE_O <= finish_w;
      if (finish_w) begin
        case (region_q)
          dsd_pkg::RGN_REG:  RDATA_O <= RD_REG_I;
          dsd_pkg::RGN_IO:   RDATA_O <= RD_IO_I;
          dsd_pkg::RGN_EXT:  RDATA_O <= RD_EXT_I;
          dsd_pkg::RGN_SRAM: RDATA_O <= RD_SRAM_I;
          default:           RDATA_O <= dsd_pkg::ZERO_BYTE;
        endcase
      end
    end
  end

  // Pointer write-back is latched at accept, issued with completion
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wb_pend_q      <= 1'b0;
      PTR_WB_VALID_O <= 1'b0;
      PTR_WB_IDX_O   <= dsd_pkg::PTR_X_LO_IDX;
      PTR_WB_VAL_O   <= dsd_pkg::REG_FIRST;
    end else begin
      if (accept_w) begin
        wb_pend_q    <= wb_w && !REQ_IO_SHORT_I;
        PTR_WB_IDX_O <= ptr_idx(REQ_PTR_SEL_I);
        PTR_WB_VAL_O <= wb_val_w;
      end
      PTR_WB_VALID_O <= finish_w && wb_pend_q;
    end
  end

  // Program counter and nonvolatile address range checks
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PC_IN_RANGE_O <= 1'b0;
      PC_IN_BOOT_O  <= 1'b0;
      NV_ADDR_OK_O  <= 1'b0;
    end else begin
      PC_IN_RANGE_O <= PROGRAM_COUNTER_I <= FLASH_LAST;
      PC_IN_BOOT_O  <= PROGRAM_COUNTER_I >= BOOT_FIRST_WORD &&
                       PROGRAM_COUNTER_I <= FLASH_LAST;
      NV_ADDR_OK_O  <= NV_ADDR_I <= NONVOLATILE_LAST_ADDRESS;
    end
  end

  // Checks on the decoder's own outputs
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_reg_window: assert property (
    SEL_REG_O |-> ADDR_O <= dsd_pkg::REG_LAST)
    else $error("register select outside register window");
  a_io_window: assert property (
    SEL_IO_O |-> ADDR_O >= dsd_pkg::IO_FIRST &&
    ADDR_O <= dsd_pkg::IO_LAST)
    else $error("standard I/O select outside its window");
  a_ext_window: assert property (
    SEL_EXT_O |-> ADDR_O >= dsd_pkg::EXT_FIRST &&
    ADDR_O <= dsd_pkg::EXT_LAST)
    else $error("extended I/O select outside its window");
  a_sram_two_cycles: assert property (
    $rose(SEL_SRAM_O) |-> !DONE_O ##1 !DONE_O ##1 DONE_O)
    else $error("SRAM access did not take two cycles");
  a_short_io_only: assert property (
    accept_w && REQ_IO_SHORT_I |=> SEL_IO_O && !SEL_EXT_O)
    else $error("short I/O access left the standard block");
  a_disp_address: assert property (
    accept_w && !REQ_IO_SHORT_I && REQ_MODE_I == dsd_pkg::MODE_DISP |=>
    ADDR_O == $past(ptr_w) + {10'h000, $past(REQ_DISP_I)})
    else $error("displacement address wrong");
  a_predec_value: assert property (
    accept_w && !REQ_IO_SHORT_I && REQ_MODE_I == dsd_pkg::MODE_PREDEC |=>
    ADDR_O == PTR_WB_VAL_O &&
    PTR_WB_VAL_O == $past(ptr_w) - dsd_pkg::PTR_STEP)
    else $error("pre-decrement address or write-back wrong");
  a_wb_with_done: assert property (PTR_WB_VALID_O |-> DONE_O)
    else $error("pointer write-back without completion");
  // While an unmapped access is held, nothing may be selected or written
  a_none_ignored: assert property (
    !READY_O && ADDR_O > INTERNAL_SRAM_LAST_ADDRESS |->
    !WR_EN_O && !SEL_REG_O && !SEL_IO_O && !SEL_EXT_O && !SEL_SRAM_O)
    else $error("unmapped access drove a write or select");
  a_none_reads_zero: assert property (
    DONE_O && ADDR_O > INTERNAL_SRAM_LAST_ADDRESS |->
    RDATA_O == dsd_pkg::ZERO_BYTE)
    else $error("unmapped read returned nonzero data");

endmodule // dsd_top

// *** verif/dsd_region_model.sv ***
/*
  Behavioural model of the four region targets behind the decoder.
  Assumes the decoder samples read data on its finishing edge while
  the select is still high; unselected data lines churn every cycle.
*/
module dsd_region_model #(
  parameter logic [7:0] KEY_REG  = 8'h5A,
  parameter logic [7:0] KEY_IO   = 8'hA5,
  parameter logic [7:0] KEY_EXT  = 8'h3C,
  parameter logic [7:0] KEY_SRAM = 8'hC3
) (
  // Clock
  input  wire logic       clk_i,
  // Access side from the decoder
  input  wire logic [15:0] addr_i,
  input  wire logic        sel_reg_i,
  input  wire logic        sel_io_i,
  input  wire logic        sel_ext_i,
  input  wire logic        sel_sram_i,
  // Read data back to the decoder
  output logic [7:0]       rd_reg_o,
  output logic [7:0]       rd_io_o,
  output logic [7:0]       rd_ext_o,
  output logic [7:0]       rd_sram_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] churn_q = 8'h00;  // Changes every cycle, stale never matches

  // Free-running pattern for deselected targets
  always_ff @(posedge clk_i) begin
    churn_q <= churn_q + 8'h35;
  end

  // Each target answers address low byte mixed with its own key
  assign rd_reg_o  = sel_reg_i  ? (addr_i[7:0] ^ KEY_REG)  : churn_q;
  assign rd_io_o   = sel_io_i   ? (addr_i[7:0] ^ KEY_IO)   : ~churn_q;
  assign rd_ext_o  = sel_ext_i  ? (addr_i[7:0] ^ KEY_EXT)  : churn_q;
  assign rd_sram_o = sel_sram_i ? (addr_i[7:0] ^ KEY_SRAM) : ~churn_q;
endmodule // dsd_region_model

// *** verif/tb_dsd_top.sv ***
/*
  Self-checking bench for the data space decoder, large variant.
  Assumes the region model answers combinationally while selected.
*/
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
  n_fail++; end end
module tb_dsd_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Read keys, indexed by region number 1..4
  localparam logic [7:0] KEY [5] = '{8'h00, 8'h5A, 8'hA5, 8'h3C, 8'hC3};
  // Region edges, program counter and nonvolatile corner values
  localparam logic [15:0] CORNER [10] = '{16'h0000, 16'h001F, 16'h0020,
    16'h005F, 16'h0060, 16'h00FF, 16'h0100, 16'h0AFF, 16'h0B00, 16'hFFFF};
  localparam logic [15:0] PCS [4] = '{16'h3FFF, 16'h4000, 16'h3000,
    16'h2FFF};
  localparam logic [11:0] NVS [4] = '{12'h3FF, 12'h400, 12'h000, 12'hFFF};
  logic clk, rst_b, valid, sh, wr, ready, done, wr_en, wb_v;
  logic s_reg, s_io, s_ext, s_sram, pc_ok, pc_boot, nv_ok;
  dsd_pkg::dsd_mode_type mode;
  dsd_pkg::dsd_ptr_type  psel;
  logic [5:0]  idx, disp;
  logic [7:0]  wd, rdata, wd_o, r_reg, r_io, r_ext, r_sram;
  logic [15:0] da, addr, wb_val, pc, pc_n;
  logic [47:0] ptrs, ptr_n;
  logic [11:0] nv, nv_n;
  logic [4:0]  wb_idx;
  int n_fail, compares, seed;

  dsd_top i_dsd_top (.REF_CLK_I(clk), .RST_B_I(rst_b),
    .REQ_VALID_I(valid), .REQ_MODE_I(mode), .REQ_PTR_SEL_I(psel),
    .REQ_IO_SHORT_I(sh), .REQ_IO_INDEX_I(idx), .REQ_DIRECT_ADDR_I(da),
    .REQ_DISP_I(disp), .REQ_WRITE_I(wr), .REQ_WDATA_I(wd),
    .PTR_REGS_I(ptrs), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata),
    .ADDR_O(addr), .SEL_REG_O(s_reg), .SEL_IO_O(s_io), .SEL_EXT_O(s_ext),
    .SEL_SRAM_O(s_sram), .WR_EN_O(wr_en), .WDATA_O(wd_o),
    .RD_REG_I(r_reg), .RD_IO_I(r_io), .RD_EXT_I(r_ext),
    .RD_SRAM_I(r_sram), .PTR_WB_VALID_O(wb_v), .PTR_WB_IDX_O(wb_idx),
    .PTR_WB_VAL_O(wb_val), .PROGRAM_COUNTER_I(pc), .NV_ADDR_I(nv),
    .PC_IN_RANGE_O(pc_ok), .PC_IN_BOOT_O(pc_boot), .NV_ADDR_OK_O(nv_ok));

  dsd_region_model #(.KEY_REG(KEY[1]), .KEY_IO(KEY[2]),
    .KEY_EXT(KEY[3]), .KEY_SRAM(KEY[4])) i_dsd_region_model (
    .clk_i(clk), .addr_i(addr), .sel_reg_i(s_reg), .sel_io_i(s_io),
    .sel_ext_i(s_ext), .sel_sram_i(s_sram), .rd_reg_o(r_reg),
    .rd_io_o(r_io), .rd_ext_o(r_ext), .rd_sram_o(r_sram));

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Region number of a data address; 0 means nothing is mapped
  function automatic int region(logic [15:0] a);
    if (a <= 16'h001F) return 1;
    if (a <= 16'h005F) return 2;
    if (a <= 16'h00FF) return 3;
    if (a <= 16'h0AFF) return 4;
    return 0;
  endfunction

  // Verdict and end of run
  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One access: drive, follow the handshake, compare every output
  task automatic access(int m, int p, logic s, logic [5:0] ix,
                        logic [15:0] d, logic [5:0] dp, logic w);
    logic [15:0] base, ea, wbx;
    logic [3:0]  esel;
    logic        wbe;
    logic [7:0]  rx;
    int          r, n;
    base = ptr_n[16*p +: 16];
    if (m == 1 && p == 0) base = ptr_n[31:16];  // Displacement uses Y
    wbe = !s && (m == 3 || m == 4);
    wbx = (m == 3) ? base - 16'h0001 : base + 16'h0001;
    ea = s ? 16'h0020 + {10'h000, ix} : m == 0 ? d :
         m == 1 ? base + {10'h000, dp} : m == 3 ? wbx : base;
    r = region(ea);
    esel = (r == 0) ? 4'h0 : 4'h8 >> (r - 1);
    // Unmapped reads come back as zero, mapped ones from the model
    rx = (r == 0) ? 8'h00 : ea[7:0] ^ KEY[r];
    @(posedge clk);
    valid <= 1'b1;
    mode <= dsd_pkg::dsd_mode_type'(m);
    psel <= dsd_pkg::dsd_ptr_type'(p);
    sh <= s;
    idx <= ix;
    da <= d;
    disp <= dp;
    wr <= w;
    wd <= 8'($random(seed));
    pc <= pc_n;
    nv <= nv_n;
    ptrs <= ptr_n;
    @(negedge clk);
    `CHK("ready", 1'b1, ready)
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    `CHK("addr", ea, addr)
    `CHK("sel", esel, {s_reg, s_io, s_ext, s_sram})
    `CHK("done_low", 1'b0, done)
    `CHK("wr_en", w && r != 0, wr_en)
    `CHK("wdata", wd, wd_o)
    `CHK("ready", 1'b0, ready)
    `CHK("pc_ok", pc_n <= 16'h3FFF, pc_ok)
    `CHK("pc_boot", pc_n >= 16'h3000 && pc_n <= 16'h3FFF, pc_boot)
    `CHK("nv_ok", nv_n <= 12'h3FF, nv_ok)
    n = 1;
    while (done !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6) begin
      n_fail++;
      report_and_stop();
    end
    `CHK("cycles", (r == 4) ? 3 : 2, n)
    if (!w) `CHK("rdata", rx, rdata)
    `CHK("wb_valid", wbe, wb_v)
    if (wbe) `CHK("wb_val", wbx, wb_val)
    if (wbe) `CHK("wb_idx", 5'(26 + 2 * p), wb_idx)
    `CHK("sel_off", 4'h0, {s_reg, s_io, s_ext, s_sram})
    `CHK("ready", 1'b1, ready)
  endtask

  // Main sequence: reset, corner cases, then random traffic
  initial begin
    seed = 32'he423_a0d5;
    rst_b = 1'b0;
    valid = 1'b0;
    sh = 1'b0;
    wr = 1'b0;
    mode = dsd_pkg::MODE_DIRECT;
    psel = dsd_pkg::PTR_X;
    idx = 6'h00;
    disp = 6'h00;
    wd = 8'h00;
    da = 16'h0000;
    pc = 16'h0000;
    ptrs = 48'h0000_0000_0000;
    ptr_n = 48'h0000_0000_0000;
    nv = 12'h000;
    pc_n = 16'h0000;
    nv_n = 12'h000;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("reset_ready", 1'b1, ready)
    `CHK("reset_done", 1'b0, done)
    @(posedge clk);
    rst_b <= 1'b1;
    // Region boundaries by direct address, read then write
    for (int i = 0; i < 20; i++) begin
      pc_n = PCS[i % 4];
      nv_n = NVS[i % 4];
      access(0, 0, 1'b0, 6'h00, CORNER[i / 2], 6'h00, i[0]);
    end
    // Short I/O at both ends of its index range, mode ignored
    access(4, 2, 1'b1, 6'h00, 16'h0000, 6'h00, 1'b0);
    access(3, 0, 1'b1, 6'h3F, 16'h0000, 6'h00, 1'b1);
    // Pointer modes with wrap, SRAM end and displacement maximum
    ptr_n = {16'h0AFF, 16'h00C1, 16'h0000};
    for (int m = 1; m < 5; m++) begin
      for (int p = 0; p < 3; p++) begin
        access(m, p, 1'b0, 6'h00, 16'h0000, 6'h3F, 1'b0);
      end
    end
    // Random traffic across the whole mapped space and beyond it
    for (int i = 0; i < 80; i++) begin
      ptr_n = 48'({$random(seed), $random(seed)}) & 48'h0FFF_0FFF_0FFF;
      pc_n = 16'($unsigned($random(seed)) % 32'h5000);
      nv_n = 12'($random(seed));
      access($unsigned($random(seed)) % 5, $unsigned($random(seed)) % 3,
             ($random(seed) & 3) == 0, 6'($random(seed)),
             16'($unsigned($random(seed)) % 32'h0C00),
             6'($random(seed)), 1'($random(seed)));
    end
    report_and_stop();
  end
endmodule // tb_dsd_top
